// ---- hw/vcp_capture_top.sv ----
// video capture packer: decoder streams packed into a two-half capture fifo
`timescale 1ns/1ps
`include "vcp_consts.svh"
// ------------------------------------------------------------
// Operation
// - two-bit format field in control register picks one of three input formats
// - 16-bit mode packs pairs of primary 4:2:2 pixels into full 32-bit words
// - 16-bit mode: pixel bit 0 set only on first pixel of even frame
// - coded single mode packs primary 8-bit pixels into full 32-bit words
// - coded modes decode timing codes, keep sync markers and valid pixels
// - blanking pixels and scaler-invalid pixels never reach the fifo
// - start of odd field marker stored as 0x06FF
// - start of active line marker stored as 0x02FF or 0x02FE
// - end of active line marker stored as 0x01FF or 0x01FE
// - dual mode: primary into bits 15:0, secondary into bits 31:16
// - dual mode halves fill independently, half-full flags ORed to one request
// - three fifo read ranges: full word, upper half, lower half
// - fifo is 512 by 32 from two 16-bit halves with half-full flag
// - 16-bit primary pixel port and 8-bit secondary pixel port
// - unreferenced half of a half-range read returns zero
// - two address lines inside the fifo bank pick the read range
// ------------------------------------------------------------
module vcp_capture_top
  import vcp_pkg::*;
#(
  parameter int DEPTH = `VCP_FIFO_DEPTH,
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // decoder pixel streams
  input vcp_pri_pix_s priPix,
  input vcp_sec_pix_s secPix,
  // request to the processor
  output logic halfFullIrq,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int LW = $clog2(DEPTH) + 1;

  // address must reach the fifo bank
  if (ADDR_W < 8)
  begin : gAddrCheck
    $error("address width below 8 cannot reach the fifo bank");
  end

  // ------------------------------------------------------------
  // register bus slave
  // ------------------------------------------------------------
  logic [1:0] fmtR, fmtNxt, ovfR, ovfNxt, ovfSet;
  logic awHeldR, awHeldNxt, wHeldR, wHeldNxt, bvalidR, bvalidNxt;
  logic [7:0] awAddrR, awAddrNxt;
  logic [31:0] wDataR, wDataNxt, rdataR, rdataNxt;
  logic [3:0] wStrbR, wStrbNxt;
  logic [1:0] brespR, brespNxt, rrespR, rrespNxt;
  logic rvalidR, rvalidNxt, doWrite, flush, arFire;
  logic [7:0] arAddr;
  logic loRd, upRd, loEmpty, upEmpty, loFull, upFull, loHf, upHf;
  logic [15:0] loRdData, upRdData;
  logic [LW-1:0] loLevel, upLevel;

  assign s_axi_awready = !awHeldR;
  assign s_axi_wready = !wHeldR;
  assign s_axi_bvalid = bvalidR;
  assign s_axi_bresp = brespR;
  assign s_axi_arready = !rvalidR;
  assign s_axi_rvalid = rvalidR;
  assign s_axi_rdata = rdataR;
  assign s_axi_rresp = rrespR;
  assign arFire = s_axi_arvalid && !rvalidR;
  assign arAddr = s_axi_araddr[7:0];
  // address and data are held until both have arrived
  assign doWrite = awHeldR && wHeldR && !bvalidR;
  assign flush = doWrite && awAddrR == `VCP_OFF_CTRL && wStrbR[0] && wDataR[1:0] != fmtR;

  // write path, control and overflow registers
  always_comb
  begin
    awHeldNxt = awHeldR;
    wHeldNxt = wHeldR;
    awAddrNxt = awAddrR;
    wDataNxt = wDataR;
    wStrbNxt = wStrbR;
    bvalidNxt = bvalidR && !s_axi_bready;
    brespNxt = brespR;
    fmtNxt = fmtR;
    ovfNxt = ovfR;
    if (s_axi_awvalid && !awHeldR)
    begin
      awHeldNxt = 1'b1;
      awAddrNxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !wHeldR)
    begin
      wHeldNxt = 1'b1;
      wDataNxt = s_axi_wdata;
      wStrbNxt = s_axi_wstrb;
    end
    if (doWrite)
    begin
      awHeldNxt = 1'b0;
      wHeldNxt = 1'b0;
      bvalidNxt = 1'b1;
      brespNxt = `VCP_RESP_OKAY;
      if (awAddrR == `VCP_OFF_CTRL && wStrbR[0])
        fmtNxt = wDataR[1:0];
      else if (awAddrR == `VCP_OFF_STATUS && wStrbR[0])
        ovfNxt = ovfR & ~wDataR[`VCP_ST_OVF_UP:`VCP_ST_OVF_LO];
      else if (awAddrR != `VCP_OFF_CTRL && awAddrR != `VCP_OFF_STATUS)
        brespNxt = `VCP_RESP_SLVERR;
    end
    // a drop in the same cycle as its clear stays visible
    ovfNxt = ovfNxt | ovfSet;
  end

  // read path: fifo pops happen on the address handshake
  always_comb
  begin
    rvalidNxt = rvalidR && !s_axi_rready;
    rdataNxt = rdataR;
    rrespNxt = rrespR;
    loRd = 1'b0;
    upRd = 1'b0;
    if (arFire)
    begin
      rvalidNxt = 1'b1;
      rrespNxt = `VCP_RESP_OKAY;
      rdataNxt = 32'h0000_0000;
      if (arAddr == `VCP_OFF_CTRL)
        rdataNxt[1:0] = fmtR;
      else if (arAddr == `VCP_OFF_STATUS)
      begin
        rdataNxt[`VCP_ST_HF_LO] = loHf;
        rdataNxt[`VCP_ST_HF_UP] = upHf;
        rdataNxt[`VCP_ST_EMPTY_LO] = loEmpty;
        rdataNxt[`VCP_ST_EMPTY_UP] = upEmpty;
        rdataNxt[`VCP_ST_OVF_UP:`VCP_ST_OVF_LO] = ovfR;
      end
      // two address lines inside the bank
      else if (arAddr[7:4] == `VCP_FIFO_BANK && arAddr[1:0] == 2'b00)
      begin
        // range select, empty reads return zero
        case (arAddr[3:2])
          `VCP_SEL_FULL:
          begin
            loRd = !loEmpty && !upEmpty;
            upRd = loRd;
            if (loRd)
              rdataNxt = {upRdData, loRdData};
          end
          `VCP_SEL_UPPER:
          begin
            upRd = !upEmpty;
            rdataNxt[15:0] = upEmpty ? 16'h0000 : upRdData;
          end
          `VCP_SEL_LOWER:
          begin
            loRd = !loEmpty;
            rdataNxt[15:0] = loEmpty ? 16'h0000 : loRdData;
          end
          default: rrespNxt = `VCP_RESP_SLVERR;
        endcase
      end
      else
        rrespNxt = `VCP_RESP_SLVERR;
    end
  end

  // bus registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      awHeldR <= 1'b0;
      wHeldR <= 1'b0;
      awAddrR <= 8'h00;
      wDataR <= 32'h0000_0000;
      wStrbR <= 4'h0;
      bvalidR <= 1'b0;
      brespR <= `VCP_RESP_OKAY;
      rvalidR <= 1'b0;
      rdataR <= 32'h0000_0000;
      rrespR <= `VCP_RESP_OKAY;
      fmtR <= `VCP_CTRL_RESET;
      ovfR <= 2'b00;
    end
    else
    begin
      awHeldR <= awHeldNxt;
      wHeldR <= wHeldNxt;
      awAddrR <= awAddrNxt;
      wDataR <= wDataNxt;
      wStrbR <= wStrbNxt;
      bvalidR <= bvalidNxt;
      brespR <= brespNxt;
      rvalidR <= rvalidNxt;
      rdataR <= rdataNxt;
      rrespR <= rrespNxt;
      fmtR <= fmtNxt;
      ovfR <= ovfNxt;
    end
  end

  // ------------------------------------------------------------
  // per stream code decode and lane packing
  // ------------------------------------------------------------
  for (genvar s = 0; s < 2; s++)
  begin : gStream
    vcp_sync_e syncR, syncNxt;
    logic actR, actNxt, fieldR, fieldNxt, byteValid, wordRdy;
    logic [7:0] codeByte, lowCode;
    logic [1:0] nIn;
    logic [15:0] bytesIn;
    logic [31:0] accR, accNxt, word;
    logic [2:0] cntR, cntNxt, total, limit;
    logic [47:0] merged;

    // primary low byte or secondary byte
    assign codeByte = (s == 0) ? priPix.data[7:0] : secPix.data;
    assign byteValid = (s == 0) ?
      (priPix.valid && (fmtR == `VCP_FMT_CODED8 || fmtR == `VCP_FMT_DUAL8)) :
      (secPix.valid && fmtR == `VCP_FMT_DUAL8);
    assign lowCode = codeByte[`VCP_XY_F] ? `VCP_LO_F1 : `VCP_LO_F0;
    assign limit = (fmtR == `VCP_FMT_DUAL8) ? `VCP_LANES_HALF : `VCP_LANES_FULL;

    // timing code decode, valid flag drops scaler rejects
    always_comb
    begin
      syncNxt = syncR;
      actNxt = actR;
      fieldNxt = fieldR;
      nIn = 2'd0;
      bytesIn = 16'h0000;
      if (s == 0 && fmtR == `VCP_FMT_PIX16)
      begin
        // whole pixel, frame start in bit 0
        if (priPix.valid)
        begin
          nIn = 2'd2;
          bytesIn = {priPix.data[15:1], priPix.frameStart};
        end
      end
      else if (byteValid)
      begin
        case (syncR)
          SYNC_PRE1: syncNxt = (codeByte == `VCP_PRE_00) ? SYNC_PRE2 : SYNC_IDLE;
          SYNC_PRE2: syncNxt = (codeByte == `VCP_PRE_00) ? SYNC_XY : SYNC_IDLE;
          SYNC_XY:
          begin
            syncNxt = SYNC_IDLE;
            actNxt = !codeByte[`VCP_XY_H] && !codeByte[`VCP_XY_V];
            fieldNxt = codeByte[`VCP_XY_F];
            // first line start of the odd field
            if (!codeByte[`VCP_XY_H] && !codeByte[`VCP_XY_F] && fieldR)
            begin
              nIn = 2'd2;
              bytesIn = {`VCP_CODE_SOF, lowCode};
            end
            // line markers, none in vertical blank
            else if (!codeByte[`VCP_XY_V])
            begin
              nIn = 2'd2;
              bytesIn = {codeByte[`VCP_XY_H] ? `VCP_CODE_EAV : `VCP_CODE_SAV, lowCode};
            end
          end
          default:
          begin
            if (codeByte == `VCP_PRE_FF)
              syncNxt = SYNC_PRE1;
            else if (actR)
            begin
              nIn = 2'd1;
              bytesIn = {8'h00, codeByte};
            end
          end
        endcase
      end
      if (flush)
      begin
        syncNxt = SYNC_IDLE;
        actNxt = 1'b0;
      end
    end

    // lowest lane first, word out when lanes full
    always_comb
    begin
      merged = {16'h0000, accR} | ({32'h0000_0000, bytesIn} << {cntR, 3'b000});
      total = cntR + {1'b0, nIn};
      word = merged[31:0];
      wordRdy = 1'b0;
      accNxt = merged[31:0];
      cntNxt = total;
      if (total >= limit)
      begin
        wordRdy = 1'b1;
        cntNxt = total - limit;
        accNxt = (limit == `VCP_LANES_FULL) ? {16'h0000, merged[47:32]} : merged[47:16];
      end
      if (flush)
      begin
        wordRdy = 1'b0;
        accNxt = 32'h0000_0000;
        cntNxt = 3'd0;
      end
    end

    // decoder and packer registers
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        syncR <= SYNC_IDLE;
        actR <= 1'b0;
        fieldR <= 1'b1;
        accR <= 32'h0000_0000;
        cntR <= 3'd0;
      end
      else
      begin
        syncR <= syncNxt;
        actR <= actNxt;
        fieldR <= fieldNxt;
        accR <= accNxt;
        cntR <= cntNxt;
      end
    end
  end

  // ------------------------------------------------------------
  // fifo halves and write steering
  // ------------------------------------------------------------
  logic single, loReq, upReq, loWr, upWr;
  logic [15:0] upWrData;

  assign single = (fmtR == `VCP_FMT_PIX16 || fmtR == `VCP_FMT_CODED8);
  // dual mode splits the halves by decoder
  assign loReq = gStream[0].wordRdy;
  assign upReq = single ? gStream[0].wordRdy : gStream[1].wordRdy;
  assign upWrData = single ? gStream[0].word[31:16] : gStream[1].word[15:0];
  // single modes write both halves or neither, keeping them aligned
  assign loWr = loReq && !loFull && !(single && upFull);
  assign upWr = upReq && !upFull && !(single && loFull);
  assign ovfSet = {upReq && !upWr, loReq && !loWr};
  assign halfFullIrq = loHf || upHf;

  vcp_fifo_half #(.WIDTH(16), .DEPTH(DEPTH)) uLowHalf (
    .clk(clk), .rst(rst), .wrEn(loWr), .wrData(gStream[0].word[15:0]),
    .rdEn(loRd), .rdData(loRdData), .empty(loEmpty), .full(loFull),
    .halfFull(loHf), .level(loLevel));
  vcp_fifo_half #(.WIDTH(16), .DEPTH(DEPTH)) uUpHalf (
    .clk(clk), .rst(rst), .wrEn(upWr), .wrData(upWrData),
    .rdEn(upRd), .rdData(upRdData), .empty(upEmpty), .full(upFull),
    .halfFull(upHf), .level(upLevel));

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqPreamble;
    gStream[0].syncR == SYNC_IDLE && gStream[0].byteValid && gStream[0].codeByte == 8'hFF
    ##1 gStream[0].byteValid && gStream[0].codeByte == 8'h00 && !flush
    ##1 gStream[0].byteValid && gStream[0].codeByte == 8'h00 && !flush;
  endsequence
  sequence seqXy(logic h);
    gStream[0].byteValid && !flush && gStream[0].codeByte[`VCP_XY_H] == h
    && !gStream[0].codeByte[`VCP_XY_V];
  endsequence

  chk_fmt_write: assert property (
    doWrite && awAddrR == `VCP_OFF_CTRL && wStrbR[0] |=> fmtR == $past(wDataR[1:0]))
    else $error("format field not taken from write");
  chk_frame_bit: assert property (
    fmtR == `VCP_FMT_PIX16 && priPix.valid && !flush
    |-> gStream[0].nIn == 2'd2 && gStream[0].bytesIn[0] == priPix.frameStart)
    else $error("frame start bit wrong in 16-bit mode");
  chk_blank_drop: assert property (
    gStream[0].byteValid && gStream[0].syncR == SYNC_IDLE && !gStream[0].actR
    |-> gStream[0].nIn == 2'd0)
    else $error("blanking byte passed to packer");
  chk_sav_marker: assert property (
    seqPreamble ##1 seqXy(1'b0) |-> gStream[0].nIn == 2'd2
    && gStream[0].bytesIn[15:8] inside {`VCP_CODE_SAV, `VCP_CODE_SOF})
    else $error("line start marker missing");
  chk_eav_marker: assert property (
    seqPreamble ##1 seqXy(1'b1) |-> gStream[0].bytesIn[15:8] == `VCP_CODE_EAV
    && gStream[0].bytesIn[7:0] inside {`VCP_LO_F0, `VCP_LO_F1})
    else $error("line end marker missing");
  chk_dual_split: assert property (
    fmtR == `VCP_FMT_DUAL8 && gStream[1].wordRdy && !gStream[0].wordRdy && !upFull
    |-> upWr && !loWr && upWrData == gStream[1].word[15:0])
    else $error("secondary word not steered to upper half");
  chk_hf_irq: assert property (
    (loLevel > LW'(DEPTH / 2) || upLevel > LW'(DEPTH / 2)) |-> halfFullIrq)
    else $error("half full request not raised");
  chk_upper_read: assert property (
    arFire && arAddr == {`VCP_FIFO_BANK, `VCP_SEL_UPPER, 2'b00} && !upEmpty && !loWr
    |=> s_axi_rvalid && loLevel == $past(loLevel) && s_axi_rdata[31:16] == 16'h0000)
    else $error("upper range read disturbed lower half");
  chk_lane_order: assert property (
    fmtR == `VCP_FMT_CODED8 && gStream[0].cntR == 3'd0 && gStream[0].nIn == 2'd1 && !flush
    |=> gStream[0].accR[7:0] == $past(gStream[0].codeByte) && gStream[0].cntR == 3'd1)
    else $error("earliest byte not in lowest lane");
  chk_flush_clear: assert property (
    flush |=> gStream[0].cntR == 3'd0 && gStream[1].cntR == 3'd0 && !loWr && !upWr)
    else $error("partial word survived format change");
endmodule : vcp_capture_top

// ---- hw/vcp_consts.svh ----
// register map, field layout and code constants of the capture packer
`ifndef VCP_CONSTS_SVH
`define VCP_CONSTS_SVH
// ------------------------------------------------------------
// register offsets and fifo bank decode
// ------------------------------------------------------------
`define VCP_OFF_CTRL 8'h00
`define VCP_OFF_STATUS 8'h04
`define VCP_FIFO_BANK 4'h1
`define VCP_SEL_FULL 2'b00
`define VCP_SEL_UPPER 2'b01
`define VCP_SEL_LOWER 2'b10
// ------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------
`define VCP_CTRL_RESET 2'b00
`define VCP_FMT_PIX16 2'b00
`define VCP_FMT_CODED8 2'b01
`define VCP_FMT_DUAL8 2'b10
`define VCP_ST_HF_LO 0
`define VCP_ST_HF_UP 1
`define VCP_ST_EMPTY_LO 2
`define VCP_ST_EMPTY_UP 3
`define VCP_ST_OVF_LO 4
`define VCP_ST_OVF_UP 5
`define VCP_RESP_OKAY 2'b00
`define VCP_RESP_SLVERR 2'b10
// ------------------------------------------------------------
// fifo geometry and packing lanes
// ------------------------------------------------------------
`define VCP_FIFO_DEPTH 512
`define VCP_LANES_FULL 3'd4
`define VCP_LANES_HALF 3'd2
// ------------------------------------------------------------
// coded stream bytes and timing flag positions
// ------------------------------------------------------------
`define VCP_PRE_FF 8'hFF
`define VCP_PRE_00 8'h00
`define VCP_XY_H 4
`define VCP_XY_V 5
`define VCP_XY_F 6
`define VCP_CODE_SOF 8'h06
`define VCP_CODE_SAV 8'h02
`define VCP_CODE_EAV 8'h01
`define VCP_LO_F0 8'hFF
`define VCP_LO_F1 8'hFE
`endif

// ---- hw/vcp_pkg.sv ----
// types shared by the capture packer files
package vcp_pkg;
  // primary decoder pixel with frame start flag
  typedef struct packed {
    logic valid;
    logic frameStart;
    logic [15:0] data;
  } vcp_pri_pix_s;
  // secondary decoder pixel
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } vcp_sec_pix_s;
  // timing reference search states
  typedef enum logic [1:0] {SYNC_IDLE, SYNC_PRE1, SYNC_PRE2, SYNC_XY} vcp_sync_e;
endpackage : vcp_pkg

// ---- hw/vcp_fifo_half.sv ----
// one 16-bit half of the capture fifo
`timescale 1ns/1ps
`include "vcp_consts.svh"
module vcp_fifo_half
  import vcp_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = `VCP_FIFO_DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  // read side
  input wire logic rdEn,
  output logic [WIDTH-1:0] rdData,
  // fill state
  output logic empty,
  output logic full,
  output logic halfFull,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
  localparam logic [AW:0] TOP = (AW+1)'(DEPTH);

  // depth must be a power of two for pointer wrap
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
  begin : gDepthCheck
    $error("fifo depth must be a power of two of at least 4");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtrR, wrPtrNxt, rdPtrR, rdPtrNxt;
  logic [AW:0] levelR, levelNxt;
  logic doWr, doRd;

  // writes into a full half and reads of an empty one are dropped
  assign doWr = wrEn && (levelR != TOP);
  assign doRd = rdEn && (levelR != '0);
  assign rdData = mem[rdPtrR];
  assign empty = (levelR == '0);
  assign full = (levelR == TOP);
  assign level = levelR;
  assign halfFull = (levelR > HALF);

  // pointer and level next values
  always_comb
  begin
    wrPtrNxt = doWr ? wrPtrR + 1'b1 : wrPtrR;
    rdPtrNxt = doRd ? rdPtrR + 1'b1 : rdPtrR;
    levelNxt = levelR + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  // pointer registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtrR <= '0;
      rdPtrR <= '0;
      levelR <= '0;
    end
    else
    begin
      wrPtrR <= wrPtrNxt;
      rdPtrR <= rdPtrNxt;
      levelR <= levelNxt;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk)
  begin
    if (doWr)
      mem[wrPtrR] <= wrData;
  end
endmodule : vcp_fifo_half

// ---- dv/vcp_dec_model.sv ----
// decoder pair model driving the primary and secondary pixel streams
`timescale 1ns/1ps
module vcp_dec_model
  import vcp_pkg::*;
(
  // pixel clock
  input wire logic clk,
  // decoder streams
  output vcp_pri_pix_s priPix,
  output vcp_sec_pix_s secPix
);
  // quiet streams until the first pixel
  initial
  begin
    priPix = '0;
    secPix = '0;
  end
  task automatic put(input logic [15:0] p, input logic f, input logic [7:0] s, input logic v);
    @(posedge clk);
    priPix <= '{valid: v, frameStart: f, data: p};
    secPix <= '{valid: v, data: s};
  endtask : put
  // idle: data inverts so a stale byte never repeats
  task automatic idle();
    @(posedge clk);
    priPix <= '{valid: 1'b0, frameStart: 1'b0, data: ~priPix.data};
    secPix <= '{valid: 1'b0, data: ~secPix.data};
  endtask : idle
  task automatic code(input logic [7:0] xy);
    put(16'h00FF, 1'b0, 8'hFF, 1'b1);
    put(16'h0000, 1'b0, 8'h00, 1'b1);
    put(16'h0000, 1'b0, 8'h00, 1'b1);
    put({8'h00, xy}, 1'b0, xy, 1'b1);
  endtask : code
endmodule : vcp_dec_model

// ---- dv/testbench.sv ----
// self-checking bench for the capture packer
`timescale 1ns/1ps
`include "vcp_consts.svh"
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin badCount++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module testbench
  import vcp_pkg::*;
;
  logic clk, rst, irq, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData, rng;
  logic [1:0] bResp, rResp;
  // strobe on the bus and the strobe the next write will use
  logic [3:0] wStrb, wrStrb;
  logic [33:0] expQ[$];
  logic [31:0] exp16[9];
  vcp_pri_pix_s priPix;
  vcp_sec_pix_s secPix;
  int badCount = 0;
  int testsRun = 0;
  vcp_capture_top #(.DEPTH(16)) u_vcp_capture_top (.clk(clk), .rst(rst),
    .priPix(priPix), .secPix(secPix), .halfFullIrq(irq), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  vcp_dec_model dec (.clk(clk), .priPix(priPix), .secPix(secPix));
  // xorshift source for pixel data
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic results();
    if (badCount == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // a wait that ran out counts as a mismatch
  task automatic guard(input int n);
    if (n >= 50)
    begin
      badCount++;
      results();
    end
  endtask : guard
  // write: address and data offered together, response awaited
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    expQ.push_back({r, 32'h0000_0000});
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    wStrb <= wrStrb;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awValid && awReady)
        awValid <= 1'b0;
      if (wValid && wReady)
        wValid <= 1'b0;
    end
    while (!(bValid && bReady) && n < 50);
    bReady <= 1'b0;
    guard(n);
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    expQ.push_back({r, d});
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arValid && arReady)
        arValid <= 1'b0;
    end
    while (!(rValid && rReady) && n < 50);
    rReady <= 1'b0;
    guard(n);
  endtask : axiRd
  // one coded byte on each stream
  task automatic px(input logic [7:0] p, input logic [7:0] s);
    dec.put({8'h00, p}, 1'b0, s, 1'b1);
  endtask : px
  // monitor: every response is matched to the oldest note
  always @(posedge clk)
  begin
    logic [33:0] e;
    if ((bValid && bReady) || (rValid && rReady))
    begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 'x;
      `CHK(bValid ? {bResp, 32'h0000_0000} : {rResp, rData}, e)
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    {awAddr, arAddr, wData} = '0;
    wStrb = 4'h0;
    wrStrb = 4'hF;
    rng = 32'd51;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    axiRd(`VCP_OFF_CTRL, 32'h0000_0000, `VCP_RESP_OKAY);
    axiRd(`VCP_OFF_STATUS, 32'h0000_000C, `VCP_RESP_OKAY);
    // 16-bit pairs, random data, marker on the very first pixel only
    for (int i = 0; i < 9; i++)
    begin
      rng = xs(rng);
      dec.put(rng[15:0], i == 0, 8'h00, 1'b1);
      dec.put(rng[31:16], 1'b0, 8'h00, 1'b1);
      exp16[i] = {rng[31:17], 1'b0, rng[15:1], i == 0};
    end
    dec.idle();
    dec.idle();
    `CHK(irq, 1'b1)
    axiRd(`VCP_OFF_STATUS, 32'h0000_0003, `VCP_RESP_OKAY);
    for (int i = 0; i < 9; i++)
      axiRd(8'h10, exp16[i], `VCP_RESP_OKAY);
    `CHK(irq, 1'b0)
    // coded single: markers, a blank cycle, bytes outside the active line
    axiWr(`VCP_OFF_CTRL, 32'h0000_0001, `VCP_RESP_OKAY);
    dec.code(8'hC0);
    px(8'hA1, 8'h55);
    px(8'hA2, 8'h55);
    dec.idle();
    px(8'hA3, 8'h55);
    px(8'hA4, 8'h55);
    dec.code(8'hD0);
    px(8'hE5, 8'h55);
    dec.code(8'h80);
    px(8'hB1, 8'h55);
    px(8'hB2, 8'h55);
    dec.idle();
    axiRd(8'h10, 32'hA2A1_02FE, `VCP_RESP_OKAY);
    axiRd(8'h10, 32'h01FE_A4A3, `VCP_RESP_OKAY);
    axiRd(8'h10, 32'hB2B1_06FF, `VCP_RESP_OKAY);
    // dual streams into separate halves, read by all three ranges
    axiWr(`VCP_OFF_CTRL, 32'h0000_0002, `VCP_RESP_OKAY);
    dec.code(8'hC0);
    px(8'h11, 8'h21);
    px(8'h12, 8'h22);
    dec.idle();
    axiRd(8'h10, 32'h02FE_02FE, `VCP_RESP_OKAY);
    axiRd(8'h14, 32'h0000_2221, `VCP_RESP_OKAY);
    axiRd(8'h18, 32'h0000_1211, `VCP_RESP_OKAY);
    // capture off stores nothing
    axiWr(`VCP_OFF_CTRL, 32'h0000_0003, `VCP_RESP_OKAY);
    px(8'h31, 8'h41);
    px(8'h32, 8'h42);
    dec.idle();
    // a control write with its low strobe off leaves the format alone
    wrStrb = 4'h0;
    axiWr(`VCP_OFF_CTRL, 32'h0000_0000, `VCP_RESP_OKAY);
    wrStrb = 4'hF;
    axiRd(`VCP_OFF_CTRL, 32'h0000_0003, `VCP_RESP_OKAY);
    axiRd(`VCP_OFF_STATUS, 32'h0000_000C, `VCP_RESP_OKAY);
    // unmapped read and a write into the fifo range are refused
    axiRd(8'h1C, 32'h0000_0000, `VCP_RESP_SLVERR);
    axiWr(8'h10, 32'hFFFF_FFFF, `VCP_RESP_SLVERR);
    // overrun in 16-bit mode: the word past a full fifo is dropped and flagged
    axiWr(`VCP_OFF_CTRL, 32'h0000_0000, `VCP_RESP_OKAY);
    repeat (34) dec.put(16'h1234, 1'b0, 8'h00, 1'b1);
    dec.idle();
    axiRd(`VCP_OFF_STATUS, 32'h0000_0033, `VCP_RESP_OKAY);
    axiWr(`VCP_OFF_STATUS, 32'h0000_0030, `VCP_RESP_OKAY);
    axiRd(`VCP_OFF_STATUS, 32'h0000_0003, `VCP_RESP_OKAY);
    repeat (2) @(posedge clk);
    results();
  end
endmodule : testbench
